// file: common/panel_pkg.sv
// package for front panel programming logic
package panel_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned TIMEOUT_S = 10;
   localparam int unsigned TIMEOUT_CYC = CLK_HZ * TIMEOUT_S;
   localparam int unsigned SCROLL_MS = 1000;
   localparam int unsigned SCROLL_CYC = CLK_HZ / 1000 * SCROLL_MS;
   localparam int unsigned DEBOUNCE_MS = 20;
   localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int unsigned REPEAT_MS = 400;
   localparam int unsigned REPEAT_CYC = CLK_HZ / 1000 * REPEAT_MS;
   localparam int unsigned NDIG = 6;
   // button index positions
   localparam int unsigned BTN_RESET = 0;
   localparam int unsigned BTN_FIRST = 1;
   localparam int unsigned BTN_SECOND = 2;
   localparam int unsigned BTN_ENTER = 3;
   localparam int unsigned BTN_PRESCALE = 4;
   localparam int unsigned BTN_LEFT = 5;
   localparam int unsigned BTN_D4 = 6;
   localparam int unsigned BTN_D3 = 7;
   // reset values, bcd digits
   localparam logic [23:0] FIRST_PRESET_RST = 24'h000500;
   localparam logic [23:0] SECOND_PRESET_RST = 24'h001000;
   localparam logic [23:0] PRESCALE_RST = 24'h100000;
   localparam logic [15:0] TIMED_RST = 16'h0010;
   localparam logic [2:0] DP_RST = 3'h0;
   typedef enum logic [6:0] {
      ST_NORMAL = 7'b0000001,
      ST_PRESET = 7'b0000010,
      ST_TIMED = 7'b0000100,
      ST_PRESCALE = 7'b0001000,
      ST_DP = 7'b0010000,
      ST_SCROLL = 7'b0100000,
      ST_DPWAIT = 7'b1000000
   } mode_t;
   typedef enum logic [4:0] {
      SH_COUNT = 5'b00001,
      SH_LBL1 = 5'b00010,
      SH_VAL1 = 5'b00100,
      SH_LBL2 = 5'b01000,
      SH_VAL2 = 5'b10000
   } show_t;
   typedef struct packed {
      logic [23:0] first_preset;
      logic [23:0] second_preset;
      logic [23:0] prescale;
      logic [15:0] timed_first;
      logic [15:0] timed_second;
      logic [2:0] dp_pos;
   } setup_t;
   typedef struct packed {
      logic [23:0] digits;
      logic [2:0] dp_pos;
      logic error_p;
      logic label_first;
      logic label_second;
   } disp_t;
endpackage

// file: src/front_panel_programming_ui.sv
// front panel command interpreter for a dual preset counter
// Functional notes
// - check stored setup at power-up; show error letter, keep running.
// - enter press clears the stored-data error letter.
// - leftmost button while enter held toggles display scrolling.
// - scroll order: label one, value one, label two, value two, count.
// - reset button acts only when enabled; zeroes or presets count.
// - active reset aborts every mode, turns outputs off, resets display.
// - preset button shows value, enters edit, ten second hold.
// - presets edit over six digits; defaults 500 and 1000.
// - counting and outputs continue during any display or edit.
// - enter before any digit change leaves without storing.
// - digit button increments digit; hold auto-repeats, wraps nine to zero.
// - enter in edit writes value to memory, effective at once.
// - ten seconds with no button held returns to normal, old value kept.
// - timed outputs 0.01 to 99.99 seconds, default 0.10.
// - reset while preset held enters timed edit, needs reset enable.
// - prescale 0.00001 to 9.99999, default 1.00000.
// - prescale button shows factor; edit only when prescale enabled.
// - leftmost press then release enters point select; next press places.
// - point chosen returns to normal at once; default no point.
// - program lockout active refuses storing any new value.
// - eight front panel buttons decoded as inputs.
// - lockout blocks prescale changes even with prescale enabled.
`timescale 1ns/1ps
module front_panel_programming_ui
   import panel_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int unsigned SCROLL_CYCLES = SCROLL_CYC,
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int unsigned REPEAT_CYCLES = REPEAT_CYC
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // front panel buttons, high while pressed
   input wire logic [7:0] buttons_i,
   // rear switches and lockout terminal
   input wire logic reset_enable_switch_i,
   input wire logic prescale_enable_switch_i,
   input wire logic program_lockout_input_i,
   // non-volatile store
   input wire panel_pkg::setup_t nv_setup_i,
   input wire logic nv_valid_i,
   input wire logic nv_check_ok_i,
   output panel_pkg::setup_t setup_o,
   output logic nv_write_o,
   // counting core
   input wire logic [23:0] count_i,
   input wire logic count_mode_preset_i,
   output logic count_clear_o,
   output logic count_load_preset_o,
   output logic outputs_off_o,
   // display
   output panel_pkg::disp_t disp_o
);
   import panel_pkg::*;

   function automatic logic [3:0] bcd_inc(input logic [3:0] d);
      return (d == 4'h9) ? 4'h0 : d + 4'h1;
   endfunction

   function automatic logic [23:0] inc_digit(input logic [23:0] v, input int unsigned k);
      logic [23:0] r;
      r = v;
      r[k*4 +: 4] = bcd_inc(v[k*4 +: 4]);
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // synchronise and debounce
   logic [7:0] sync1_q, sync2_q, stable_q, prev_q;
   logic [31:0] deb_cnt_q [8];
   wire logic [7:0] press_w = stable_q & ~prev_q;
   wire logic [7:0] release_w = ~stable_q & prev_q;
   // rear switches and lockout terminal pass two flops as well
   logic [2:0] sw1_q;
   logic [2:0] sw2_q;
   wire logic rst_en_w = sw2_q[2];
   wire logic ps_en_w = sw2_q[1];
   wire logic lockout_w = sw2_q[0];

   always_ff @(posedge clk_sys_i) begin
      sync1_q <= buttons_i;
      sync2_q <= sync1_q;
      sw1_q <= {reset_enable_switch_i, prescale_enable_switch_i, program_lockout_input_i};
      sw2_q <= sw1_q;
      prev_q <= stable_q;
      if (rst_i) begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
         prev_q <= 8'h00;
      end
   end

   // one debounce counter for each of the eight buttons
   always_ff @(posedge clk_sys_i) begin
      for (int b = 0; b < 8; b++) begin
         if (rst_i) begin
            stable_q[b] <= 1'b0;
            deb_cnt_q[b] <= 32'h0;
         end else if (sync2_q[b] == stable_q[b]) begin
            deb_cnt_q[b] <= 32'h0;
         end else if (deb_cnt_q[b] >= DEBOUNCE_CYCLES - 1) begin
            stable_q[b] <= sync2_q[b];
            deb_cnt_q[b] <= 32'h0;
         end else begin
            deb_cnt_q[b] <= deb_cnt_q[b] + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // auto repeat on held digit buttons
   logic [31:0] rep_cnt_q;
   wire logic rep_tick_w = (rep_cnt_q >= REPEAT_CYCLES - 1);
   // digit buttons: leftmost .. rightmost map to digit 5 .. 0
   wire logic [5:0] dig_btn_w = {stable_q[BTN_LEFT], stable_q[BTN_D4], stable_q[BTN_D3],
                                 stable_q[BTN_PRESCALE], stable_q[BTN_SECOND],
                                 stable_q[BTN_FIRST]};
   wire logic [5:0] dig_press_w = {press_w[BTN_LEFT], press_w[BTN_D4], press_w[BTN_D3],
                                   press_w[BTN_PRESCALE], press_w[BTN_SECOND],
                                   press_w[BTN_FIRST]};
   wire logic [5:0] dig_ev_w = dig_press_w | (rep_tick_w ? dig_btn_w : 6'h00);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || dig_btn_w == 6'h00 || rep_tick_w || dig_press_w != 6'h00) begin
         rep_cnt_q <= 32'h0;
      end else begin
         rep_cnt_q <= rep_cnt_q + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode machine
   mode_t mode_q, mode_d;
   show_t show_q, show_d;
   setup_t setup_q, setup_d;
   logic [23:0] edit_q, edit_d;
   logic sel_q, sel_d;
   logic changed_q, changed_d;
   logic err_q, err_d;
   logic chk_q;
   logic [31:0] tmo_q, scr_q;
   logic nv_wr_d;

   wire logic held_w = |stable_q;
   wire logic timeout_w = (tmo_q >= TIMEOUT_CYCLES - 1);
   wire logic scr_tick_w = (scr_q >= SCROLL_CYCLES - 1);
   wire logic enter_w = press_w[BTN_ENTER];
   wire logic reset_ev_w = press_w[BTN_RESET] & rst_en_w;
   wire logic edit_mode_w = (mode_q == ST_PRESET) || (mode_q == ST_TIMED)
                            || (mode_q == ST_PRESCALE);
   wire logic edit_ok_w = ~lockout_w
                          && (mode_q != ST_PRESCALE || ps_en_w);
   wire logic timed_ev_w = reset_ev_w && (stable_q[BTN_FIRST] || stable_q[BTN_SECOND]);

   ////////////////////////////////////////////////////////////////////////
   // opening press of a preset or prescale button must not count as a digit step
   logic open_q;
   wire logic held_mask_w = open_q;

   always_comb begin
      mode_d = mode_q;
      show_d = show_q;
      setup_d = setup_q;
      edit_d = edit_q;
      sel_d = sel_q;
      changed_d = changed_q;
      err_d = err_q;
      nv_wr_d = 1'b0;
      if (err_q && enter_w) begin
         err_d = 1'b0;
      end
      // a failed check in the same cycle as enter still wins
      if (!chk_q && nv_valid_i) begin
         setup_d = nv_setup_i;
         err_d = ~nv_check_ok_i;
      end
      if (timed_ev_w) begin
         mode_d = ST_TIMED;
         sel_d = stable_q[BTN_SECOND];
         edit_d = {8'h00, stable_q[BTN_SECOND] ? setup_q.timed_second : setup_q.timed_first};
         changed_d = 1'b0;
      end else if (reset_ev_w) begin
         mode_d = ST_NORMAL;
         show_d = SH_COUNT;
      end else begin
         case (mode_q)
            ST_NORMAL, ST_SCROLL: begin
               if (stable_q[BTN_ENTER] && press_w[BTN_LEFT]) begin
                  mode_d = (mode_q == ST_SCROLL) ? ST_NORMAL : ST_SCROLL;
                  show_d = (mode_q == ST_SCROLL) ? SH_COUNT : SH_LBL1;
               end else if (press_w[BTN_FIRST] || press_w[BTN_SECOND]) begin
                  mode_d = ST_PRESET;
                  sel_d = press_w[BTN_SECOND];
                  edit_d = press_w[BTN_SECOND] ? setup_q.second_preset : setup_q.first_preset;
                  changed_d = 1'b0;
               end else if (press_w[BTN_PRESCALE]) begin
                  mode_d = ST_PRESCALE;
                  edit_d = setup_q.prescale;
                  changed_d = 1'b0;
               end else if (press_w[BTN_LEFT]) begin
                  mode_d = ST_DPWAIT;
               end else if (mode_q == ST_SCROLL && scr_tick_w) begin
                  case (show_q)
                     SH_LBL1: show_d = SH_VAL1;
                     SH_VAL1: show_d = SH_LBL2;
                     SH_LBL2: show_d = SH_VAL2;
                     SH_VAL2: show_d = SH_COUNT;
                     default: show_d = SH_LBL1;
                  endcase
               end
            end
            ST_DPWAIT: begin
               if (release_w[BTN_LEFT]) begin
                  mode_d = ST_DP;
               end
            end
            ST_DP: begin
               if (dig_press_w != 6'h00) begin
                  mode_d = ST_NORMAL;
                  if (!lockout_w) begin
                     for (int k = 0; k < NDIG; k++) begin
                        if (dig_press_w[k]) begin
                           setup_d.dp_pos = 3'(k);
                        end
                     end
                     nv_wr_d = 1'b1;
                  end
               end else if (timeout_w) begin
                  mode_d = ST_NORMAL;
               end
            end
            default: begin
               // edit modes; counting core keeps running meanwhile
               if (enter_w) begin
                  mode_d = ST_NORMAL;
                  if (changed_q && edit_ok_w) begin
                     nv_wr_d = 1'b1;
                     if (mode_q == ST_PRESET && !sel_q) setup_d.first_preset = edit_q;
                     if (mode_q == ST_PRESET && sel_q) setup_d.second_preset = edit_q;
                     if (mode_q == ST_PRESCALE) setup_d.prescale = edit_q;
                     if (mode_q == ST_TIMED && !sel_q) setup_d.timed_first = edit_q[15:0];
                     if (mode_q == ST_TIMED && sel_q) setup_d.timed_second = edit_q[15:0];
                  end
               end else if (timeout_w) begin
                  mode_d = ST_NORMAL;
               end else if (dig_ev_w != 6'h00 && edit_ok_w && !held_mask_w) begin
                  for (int k = 0; k < NDIG; k++) begin
                     if (dig_ev_w[k] && (mode_q != ST_TIMED || k < 4)) begin
                        edit_d = inc_digit(edit_d, k);
                        changed_d = 1'b1;
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         open_q <= 1'b0;
      end else if (mode_q != mode_d && mode_d != ST_NORMAL) begin
         open_q <= 1'b1;
      end else if (dig_btn_w == 6'h00) begin
         open_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         mode_q <= ST_NORMAL;
         show_q <= SH_COUNT;
         setup_q <= '{FIRST_PRESET_RST, SECOND_PRESET_RST, PRESCALE_RST,
                      TIMED_RST, TIMED_RST, DP_RST};
         edit_q <= 24'h000000;
         sel_q <= 1'b0;
         changed_q <= 1'b0;
         err_q <= 1'b0;
         chk_q <= 1'b0;
         nv_write_o <= 1'b0;
      end else begin
         mode_q <= mode_d;
         show_q <= show_d;
         setup_q <= setup_d;
         edit_q <= edit_d;
         sel_q <= sel_d;
         changed_q <= changed_d;
         err_q <= err_d;
         chk_q <= chk_q | nv_valid_i;
         nv_write_o <= nv_wr_d;
      end
   end

   // ten second hold restarts while any button is held
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || mode_q != mode_d || held_w) begin
         tmo_q <= 32'h0;
      end else if (!timeout_w) begin
         tmo_q <= tmo_q + 32'h1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i || mode_q != ST_SCROLL || scr_tick_w) begin
         scr_q <= 32'h0;
      end else begin
         scr_q <= scr_q + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs toward core and display
   wire logic [23:0] shown_w =
      edit_mode_w ? edit_q :
      (show_q == SH_VAL1) ? setup_q.first_preset :
      (show_q == SH_VAL2) ? setup_q.second_preset : count_i;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         count_clear_o <= 1'b0;
         count_load_preset_o <= 1'b0;
         outputs_off_o <= 1'b0;
         disp_o <= '0;
         setup_o <= '0;
      end else begin
         count_clear_o <= reset_ev_w && !timed_ev_w && !count_mode_preset_i;
         count_load_preset_o <= reset_ev_w && !timed_ev_w && count_mode_preset_i;
         outputs_off_o <= reset_ev_w && !timed_ev_w;
         disp_o.digits <= shown_w;
         disp_o.dp_pos <= setup_q.dp_pos;
         disp_o.error_p <= err_q;
         disp_o.label_first <= (mode_q == ST_SCROLL) && (show_q == SH_LBL1);
         disp_o.label_second <= (mode_q == ST_SCROLL) && (show_q == SH_LBL2);
         setup_o <= setup_q;
      end
   end
endmodule // front_panel_programming_ui

// file: tb/front_panel_programming_ui_sva.sv
// checker for the front panel command interpreter ports
`timescale 1ns/1ps
module front_panel_programming_ui_sva
   import panel_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic reset_enable_switch_i,
   input wire logic program_lockout_input_i,
   input wire logic nv_valid_i,
   input wire logic count_mode_preset_i,
   input wire panel_pkg::setup_t setup_o,
   input wire logic nv_write_o,
   input wire logic count_clear_o,
   input wire logic count_load_preset_o,
   input wire logic outputs_off_o,
   input wire panel_pkg::disp_t disp_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   a_reset_gated: assert property ((count_clear_o || count_load_preset_o)
      |-> $past(reset_enable_switch_i, 3))
      else $error("reset acted while disabled");
   a_clear_mode: assert property (count_clear_o |-> !count_load_preset_o && !count_mode_preset_i)
      else $error("clear in wrong mode");
   a_load_mode: assert property (count_load_preset_o |-> count_mode_preset_i)
      else $error("preset load in wrong mode");
   a_off_on_reset: assert property ((count_clear_o || count_load_preset_o) |-> outputs_off_o)
      else $error("outputs not turned off");
   a_clear_single: assert property (count_clear_o |=> !count_clear_o)
      else $error("clear pulse too long");
   a_write_locked: assert property (nv_write_o |-> !$past(program_lockout_input_i, 3))
      else $error("store while locked out");
   a_write_single: assert property (nv_write_o |=> !nv_write_o)
      else $error("write pulse too long");
   a_setup_cause: assert property ($changed(setup_o) |-> $past(nv_write_o) || $past(nv_write_o, 2)
      || $past(nv_valid_i, 2) || $past(rst_i) || $past(rst_i, 2))
      else $error("setup changed without a write");
   a_error_cause: assert property ($rose(disp_o.error_p) |-> $past(nv_valid_i)
      || $past(nv_valid_i, 2) || $past(nv_valid_i, 3))
      else $error("error letter without check");
   a_point_range: assert property (disp_o.dp_pos <= 3'h5)
      else $error("point position out of range");
   c_write: cover property (nv_write_o);
   c_load: cover property (count_load_preset_o);
   c_err_clear: cover property ($fell(disp_o.error_p));
   c_scroll: cover property (disp_o.label_second);
endmodule // front_panel_programming_ui_sva
bind front_panel_programming_ui front_panel_programming_ui_sva i_sva (.clk_sys_i, .rst_i,
   .reset_enable_switch_i, .program_lockout_input_i, .nv_valid_i, .count_mode_preset_i,
   .setup_o, .nv_write_o, .count_clear_o, .count_load_preset_o, .outputs_off_o, .disp_o);

// file: tb/operator_model.sv
// operator model: presses panel buttons with contact chatter
`timescale 1ns/1ps
module operator_model (
   // clock
   input wire logic clk_sys_i,
   // wanted button levels
   input wire logic [7:0] want_i,
   // raw button lines
   output logic [7:0] buttons_o
);
   logic [7:0] last_q = 8'h00;
   logic [7:0] mask_q = 8'h00;
   logic [1:0] left_q = 2'h0;
   initial begin
      buttons_o = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // changed contacts chatter for three cycles, then settle
   always @(posedge clk_sys_i) begin
      last_q <= want_i;
      if (want_i != last_q) begin
         mask_q <= want_i ^ last_q;
         left_q <= 2'h3;
      end else if (left_q != 2'h0) begin
         left_q <= left_q - 2'h1;
      end
      buttons_o <= (left_q != 2'h0) ? (buttons_o ^ mask_q) : last_q;
   end
endmodule // operator_model

// file: tb/tb.sv
// testbench for the front panel command interpreter
`timescale 1ns/1ps
module tb;
   import panel_pkg::*;
   localparam int unsigned TO = 300;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] want = 8'h00;
   logic [7:0] buttons;
   logic rst_en = 1'b1, ps_en = 1'b1, lock = 1'b0, nv_valid = 1'b0, mode_p = 1'b0;
   logic nv_ok = 1'b0;
   logic [23:0] count = 24'h123456;
   setup_t def = '{FIRST_PRESET_RST, SECOND_PRESET_RST, PRESCALE_RST, TIMED_RST, TIMED_RST, DP_RST};
   setup_t setup;
   disp_t disp;
   logic nv_write, clr, ld, off;
   logic [7:0] clrs = 8'h00, lds = 8'h00, writes = 8'h00, offs = 8'h00;
   int failures = 0, tests_run = 0;
   initial begin
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      if (nv_write === 1'b1) writes <= writes + 8'h01;
      if (clr === 1'b1) clrs <= clrs + 8'h01;
      if (ld === 1'b1) lds <= lds + 8'h01;
      if (off === 1'b1) offs <= offs + 8'h01;
   end
   operator_model i_op (.clk_sys_i(clk_sys_i), .want_i(want), .buttons_o(buttons));
   front_panel_programming_ui #(.TIMEOUT_CYCLES(TO), .SCROLL_CYCLES(20), .DEBOUNCE_CYCLES(3),
      .REPEAT_CYCLES(30)) i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .buttons_i(buttons),
      .reset_enable_switch_i(rst_en), .prescale_enable_switch_i(ps_en),
      .program_lockout_input_i(lock), .nv_setup_i(def), .nv_valid_i(nv_valid),
      .nv_check_ok_i(nv_ok), .setup_o(setup), .nv_write_o(nv_write), .count_i(count),
      .count_mode_preset_i(mode_p), .count_clear_o(clr), .count_load_preset_o(ld),
      .outputs_off_o(off), .disp_o(disp));
   ////////////////////////////////////////////////////////////////////////////////
   task cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task press(input int b, input int n, input int hold);
      repeat (n) begin
         want[b] <= 1'b1;
         cyc(hold);
         want[b] <= 1'b0;
         cyc(12);
      end
   endtask
   task chk(input logic [106:0] got, input logic [106:0] exp, input string m);
      @(negedge clk_sys_i);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
      end
      @(posedge clk_sys_i);
   endtask
   task end_of_test;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task wait_show(input int k);
      int i;
      for (i = 0; i < 400; i++) begin
         @(negedge clk_sys_i);
         if ((k == 0) ? disp.label_first === 1'b1 : (k == 1) ? disp.label_second === 1'b1 :
            (disp.label_first === 1'b0 && disp.label_second === 1'b0 && disp.digits === count)) begin
            @(posedge clk_sys_i);
            return;
         end
      end
      failures++;
      $display("mismatch %0t scroll step %0d missing", $time, k);
      end_of_test();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int i;
      logic [1:0] lbl;
      cyc(16);
      rst_i <= 1'b0;
      cyc(4);
      chk(setup, def, "defaults");
      nv_valid <= 1'b1;
      cyc(1);
      nv_valid <= 1'b0;
      cyc(4);
      chk(disp.error_p, 1'b1, "error letter");
      chk(disp.digits, count, "count shown");
      press(BTN_ENTER, 1, 10);
      chk(disp.error_p, 1'b0, "error clear");
      press(BTN_FIRST, 1, 10);
      chk(disp.digits, 24'h000500, "preset shown");
      press(BTN_FIRST, 2, 10);
      press(BTN_ENTER, 1, 10);
      chk(setup.first_preset, 24'h000502, "preset stored");
      chk(writes, 8'h01, "one write");
      press(BTN_FIRST, 1, 10);
      press(BTN_ENTER, 1, 10);
      chk(writes, 8'h01, "unchanged exit");
      press(BTN_SECOND, 1, 10);
      press(BTN_D3, 9, 10);
      press(BTN_ENTER, 1, 10);
      chk(setup.second_preset, 24'h000000, "digit wrap");
      press(BTN_SECOND, 1, 10);
      press(BTN_FIRST, 1, 80);
      press(BTN_ENTER, 1, 10);
      chk(setup.second_preset, 24'h000003, "auto repeat");
      press(BTN_FIRST, 2, 10);
      cyc(TO + 40);
      chk(disp.digits, count, "timeout display");
      chk(setup.first_preset, 24'h000502, "timeout keeps");
      for (i = 0; i < 3; i++) begin
         lock <= (i == 0);
         ps_en <= (i != 1);
         press(BTN_PRESCALE, 1, 10);
         press(BTN_FIRST, 1, 10);
         press(BTN_ENTER, 1, 10);
         chk(setup.prescale, (i == 2) ? 24'h100001 : PRESCALE_RST, "prescale");
      end
      want[BTN_FIRST] <= 1'b1;
      cyc(12);
      press(BTN_RESET, 1, 10);
      want[BTN_FIRST] <= 1'b0;
      cyc(12);
      chk(disp.digits[15:0], TIMED_RST, "timed shown");
      press(BTN_FIRST, 1, 10);
      press(BTN_ENTER, 1, 10);
      chk(setup.timed_first, 16'h0011, "timed stored");
      for (i = 0; i < 3; i++) begin
         rst_en <= (i != 0);
         mode_p <= (i == 2);
         press(BTN_RESET, 1, 10);
         chk({clrs, lds}, (i == 0) ? 16'h0000 : (i == 1) ? 16'h0100 : 16'h0101, "reset");
         chk(offs, 8'(i), "outputs off");
      end
      press(BTN_FIRST, 1, 10);
      press(BTN_RESET, 1, 10);
      chk(disp.digits, count, "reset aborts");
      chk(offs, 8'h03, "abort outputs off");
      press(BTN_LEFT, 1, 10);
      press(BTN_PRESCALE, 1, 10);
      chk(disp.dp_pos, 3'h2, "point placed");
      press(BTN_LEFT, 1, 10);
      press(BTN_FIRST, 1, 10);
      chk(disp.dp_pos, 3'h0, "point off");
      want[BTN_ENTER] <= 1'b1;
      cyc(12);
      press(BTN_LEFT, 1, 10);
      want[BTN_ENTER] <= 1'b0;
      wait_show(0);
      wait_show(1);
      wait_show(2);
      want[BTN_ENTER] <= 1'b1;
      cyc(12);
      press(BTN_LEFT, 1, 10);
      want[BTN_ENTER] <= 1'b0;
      lbl = 2'b00;
      repeat (120) begin
         @(negedge clk_sys_i);
         lbl = lbl | {disp.label_first, disp.label_second};
      end
      chk(lbl, 2'b00, "scroll stop");
      nv_ok <= 1'b1;
      rst_i <= 1'b1;
      cyc(2);
      rst_i <= 1'b0;
      cyc(2);
      nv_valid <= 1'b1;
      cyc(1);
      nv_valid <= 1'b0;
      cyc(4);
      chk(disp.error_p, 1'b0, "good stored data");
      chk(setup, def, "reset restores setup");
      end_of_test();
   end
endmodule // tb
